// File: shared/ccp_pkg.sv
// Package: constants and carrier types for the clock output pin control block
package ccp_pkg;

    // Sizes of the documented device
    localparam int NUM_OUT = 5;
    localparam int NUM_SYNTH = 2;
    localparam int NUM_OE_PIN = 4;
    localparam int NUM_PROF_PIN = 1;
    localparam int SYNC_STAGES = 3;

    // Integer divider limits
    localparam logic [7:0] DIV_MIN = 8'h08;
    localparam logic [7:0] DIV_MAX = 8'hff;

    // Skew steps
    localparam int SKEW_STEP_PS = 35;
    localparam int SKEW_RANGE_PS = 245;
    localparam logic [2:0] SKEW_MAX_STEPS = 3'(SKEW_RANGE_PS / SKEW_STEP_PS);

    // Spread magnitude in units of 0.1 percent
    localparam logic [4:0] SPREAD_MAG_MIN = 5'h01;
    localparam logic [4:0] SPREAD_MAG_MAX = 5'h19;

    // Serial target address
    localparam logic [6:0] TARGET_ADDR_BASE = 7'h6a;

    // Timing
    localparam int CLK_MHZ = 250;
    localparam int OE_DISABLE_MIN_PERIODS = 2;
    localparam int OE_DISABLE_MAX_PERIODS = 6;
    localparam int REENABLE_MAX_US = 20;
    localparam int REENABLE_MAX_CYC = REENABLE_MAX_US * CLK_MHZ;
    localparam logic [1:0] BOOT_SETTLE_CYC = 2'h3;

    // Input source choices
    localparam logic [1:0] SRC_CRYSTAL = 2'h0;
    localparam logic [1:0] SRC_CLOCK_TWO = 2'h1;
    localparam logic [1:0] SRC_CLOCK_THREE = 2'h2;

    typedef enum {BOOT_WAIT, BOOT_LOAD, BOOT_RUN} ccp_boot_type;

    // Per output pair configuration
    typedef struct packed {
        logic [7:0] divA;
        logic [7:0] divB;
        logic fsFromPin;
        logic fsRegSel;
        logic singleEnded;
        logic trueInvert;
        logic compInvert;
        logic [2:0] skewSteps;
        logic oeFromPin;
        logic [1:0] oePinIdx;
        logic oeRegEnable;
    } ccp_out_cfg_type;

    // Per fractional synthesizer configuration, two spread profiles
    typedef struct packed {
        logic spreadFromPin;
        logic spreadRegEn;
        logic fsFromPin;
        logic fsRegSel;
        logic centerA;
        logic [4:0] magA;
        logic centerB;
        logic [4:0] magB;
    } ccp_synth_cfg_type;

    // Global configuration
    typedef struct packed {
        logic srcFromPin;
        logic [1:0] srcReg;
        logic addrFromPin;
    } ccp_misc_cfg_type;

    // Spread control handed to a fractional synthesizer
    typedef struct packed {
        logic spreadOn;
        logic center;
        logic [4:0] magnitude;
        logic altProfile;
    } ccp_spread_type;

    // One output pair at the driver
    typedef struct packed {
        logic truePin;
        logic compPin;
        logic driverOn;
        logic [2:0] skewSteps;
    } ccp_pair_type;

endpackage

// File: design/ccp_clock_output_ctrl.sv
// Design: control pins, volatile configuration and output pair gating of the clock generator
`timescale 1ns/10ps
// Functional notes
// - Single-ended pair drives both pins, polarity configurable
// - Enable pin low enables, high disables
// - Per-output skew in 35 ps steps, 245 ps
// - Enable and disable only at period end
// - Center or down spread, 0.1 to 2.5 percent
// - Spread per fractional synthesizer, independent profiles
// - Assigned pin overrides same register bits
// - Spread pin 0 off, 1 on, immediate
// - Divider select pin: 0 value A, 1 B
// - Divide values 8 through 255 accepted
// - Synth select pin picks alternate profile
// - Enable pin maps to output, bank, all
// - Disable within 2-6 periods, re-enable under 20 us
// - Single-ended pair enabled and disabled together
// - Address pin sets target address LSB
// - Input select pins choose source, may glitch
// - Profile pins pick stored configuration at power-up
// - Serial target supports standard, fast, fast-plus
// - Serial writes change volatile configuration only
// - Stored configuration runs outputs without host
module ccp_clock_output_ctrl #(
    parameter int NUM_OUT = ccp_pkg::NUM_OUT,
    parameter int NUM_SYNTH = ccp_pkg::NUM_SYNTH,
    parameter int NUM_OE_PIN = ccp_pkg::NUM_OE_PIN,
    parameter int NUM_PROF_PIN = ccp_pkg::NUM_PROF_PIN,
    parameter int REENABLE_MAX_CYC = ccp_pkg::REENABLE_MAX_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control pins, asynchronous to clk
    input wire logic [NUM_SYNTH-1:0] spreadEnablePins,
    input wire logic [NUM_OUT-1:0] integerFreqSelect,
    input wire logic [NUM_SYNTH-1:0] fractionalFreqSelect,
    input wire logic [NUM_OE_PIN-1:0] outputEnableLowPins,
    input wire logic addrSelectPin,
    input wire logic [1:0] inputSourceSelect,
    input wire logic [NUM_PROF_PIN-1:0] profileSelectPins,
    // Stored profiles
    input wire ccp_pkg::ccp_out_cfg_type [2**NUM_PROF_PIN-1:0][NUM_OUT-1:0] nvmOutCfg,
    input wire ccp_pkg::ccp_synth_cfg_type [2**NUM_PROF_PIN-1:0][NUM_SYNTH-1:0] nvmSynthCfg,
    input wire ccp_pkg::ccp_misc_cfg_type [2**NUM_PROF_PIN-1:0] nvmMiscCfg,
    // Volatile writes from the serial target
    input wire logic hostOutWr,
    input wire logic [$clog2(NUM_OUT)-1:0] hostOutIdx,
    input wire ccp_pkg::ccp_out_cfg_type hostOutData,
    input wire logic hostSynthWr,
    input wire logic [$clog2(NUM_SYNTH)-1:0] hostSynthIdx,
    input wire ccp_pkg::ccp_synth_cfg_type hostSynthData,
    input wire logic hostMiscWr,
    input wire ccp_pkg::ccp_misc_cfg_type hostMiscData,
    // Output pairs and status
    output ccp_pkg::ccp_pair_type [NUM_OUT-1:0] outPairs,
    output ccp_pkg::ccp_spread_type [NUM_SYNTH-1:0] synthSpread,
    output logic [6:0] targetAddr,
    output logic [1:0] sourceSelect,
    output logic bootDone
);
    import ccp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    localparam int NUM_PINS = 2 * NUM_SYNTH + NUM_OUT + NUM_OE_PIN + 3 + NUM_PROF_PIN;

    generate
        if (NUM_OUT < 1 || NUM_SYNTH < 1 || NUM_OE_PIN < 1 || NUM_OE_PIN > 4)
        begin : gBadSize
            $error("ccp_clock_output_ctrl: unsupported sizes");
        end
        // Index ports would collapse to no bits below two entries
        if (NUM_OUT < 2 || NUM_SYNTH < 2)
        begin : gBadIdx
            $error("ccp_clock_output_ctrl: index ports need two entries");
        end
        if (NUM_PROF_PIN < 1 || NUM_PROF_PIN > 4)
        begin : gBadProf
            $error("ccp_clock_output_ctrl: unsupported profile pin count");
        end
        // Two longest periods must fit the re-enable budget
        if (REENABLE_MAX_CYC < 2 * int'(DIV_MAX))
        begin : gBadReenable
            $error("ccp_clock_output_ctrl: re-enable budget too short");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [NUM_PINS-1:0] pinRaw;
    logic [NUM_PINS-1:0] pinS1_q;
    logic [NUM_PINS-1:0] pinS2_q;
    logic [NUM_PINS-1:0] pinS3_q;
    logic [NUM_PINS-1:0] pinStable_q;
    logic [NUM_PINS-1:0] pinStable_d;

    assign pinRaw = {profileSelectPins, inputSourceSelect, addrSelectPin, outputEnableLowPins,
        fractionalFreqSelect, integerFreqSelect, spreadEnablePins};
    // Accept a level only when stages two and three agree
    assign pinStable_d = (pinS2_q & pinS3_q) | (pinStable_q & (pinS2_q | pinS3_q));

    always_ff @(posedge clk)
    begin
        pinS1_q <= pinRaw;
        pinS2_q <= pinS1_q;
        pinS3_q <= pinS2_q;
        pinStable_q <= pinStable_d;
    end

    wire [NUM_SYNTH-1:0] spreadPin = pinStable_q[NUM_SYNTH-1:0];
    wire [NUM_OUT-1:0] intFsPin = pinStable_q[NUM_SYNTH +: NUM_OUT];
    wire [NUM_SYNTH-1:0] fracFsPin = pinStable_q[NUM_SYNTH+NUM_OUT +: NUM_SYNTH];
    wire [NUM_OE_PIN-1:0] oeLowPin = pinStable_q[2*NUM_SYNTH+NUM_OUT +: NUM_OE_PIN];
    wire addrPin = pinStable_q[2*NUM_SYNTH+NUM_OUT+NUM_OE_PIN];
    wire [1:0] srcPin = pinStable_q[2*NUM_SYNTH+NUM_OUT+NUM_OE_PIN+1 +: 2];
    wire [NUM_PROF_PIN-1:0] profPin = pinStable_q[NUM_PINS-NUM_PROF_PIN +: NUM_PROF_PIN];

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up profile load and volatile configuration

    ccp_boot_type bootState_q;
    ccp_boot_type bootState_d;
    logic [1:0] bootCnt_q;
    logic [NUM_PROF_PIN-1:0] profile_q;
    ccp_out_cfg_type [NUM_OUT-1:0] outCfg_q;
    ccp_synth_cfg_type [NUM_SYNTH-1:0] synthCfg_q;
    ccp_misc_cfg_type miscCfg_q;
    logic bootDone_q;

    // Profile pins are only read once the synchroniser has settled
    wire bootSettled = (bootCnt_q == BOOT_SETTLE_CYC);
    wire bootLoad = (bootState_q == BOOT_LOAD);
    wire hostOpen = (bootState_q == BOOT_RUN);

    always_comb
    begin
        case (bootState_q)
            BOOT_WAIT: bootState_d = bootSettled ? BOOT_LOAD : BOOT_WAIT;
            BOOT_LOAD: bootState_d = BOOT_RUN;
            BOOT_RUN: bootState_d = BOOT_RUN;
            default: bootState_d = BOOT_WAIT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            bootState_q <= BOOT_WAIT;
            bootCnt_q <= '0;
            profile_q <= '0;
            bootDone_q <= 1'b0;
        end
        else
        begin
            bootState_q <= bootState_d;
            if (!bootSettled)
                bootCnt_q <= bootCnt_q + 2'h1;
            if (bootSettled && bootState_q == BOOT_WAIT)
                profile_q <= profPin;
            bootDone_q <= hostOpen;
        end
    end

    // Stored image runs the outputs with no host access
    // Host writes land only in these volatile copies
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            outCfg_q <= '0;
            synthCfg_q <= '0;
            miscCfg_q <= '0;
        end
        else if (bootLoad)
        begin
            outCfg_q <= nvmOutCfg[profile_q];
            synthCfg_q <= nvmSynthCfg[profile_q];
            miscCfg_q <= nvmMiscCfg[profile_q];
        end
        else if (hostOpen)
        begin
            if (hostOutWr && int'(hostOutIdx) < NUM_OUT)
                outCfg_q[hostOutIdx] <= hostOutData;
            if (hostSynthWr && int'(hostSynthIdx) < NUM_SYNTH)
                synthCfg_q[hostSynthIdx] <= hostSynthData;
            if (hostMiscWr)
                miscCfg_q <= hostMiscData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Target address and input source

    logic [6:0] targetAddr_q;
    logic [1:0] sourceSelect_q;

    // Lowest address bit follows the pin when assigned
    wire addrLsb = miscCfg_q.addrFromPin ? addrPin : TARGET_ADDR_BASE[0];
    // Source switches at once; glitches are left to the board
    wire [1:0] srcSel = miscCfg_q.srcFromPin ? srcPin : miscCfg_q.srcReg;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            targetAddr_q <= TARGET_ADDR_BASE;
            sourceSelect_q <= SRC_CRYSTAL;
        end
        else
        begin
            targetAddr_q <= {TARGET_ADDR_BASE[6:1], addrLsb};
            sourceSelect_q <= (srcSel == 2'h3) ? SRC_CRYSTAL : srcSel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Spread control per fractional synthesizer

    genvar s;
    generate
        for (s = 0; s < NUM_SYNTH; s++)
        begin : gSynth
            ccp_spread_type spread_q;
            // Pin overrides the register enable; no smoothing on change
            wire spreadOn = synthCfg_q[s].spreadFromPin ? spreadPin[s] : synthCfg_q[s].spreadRegEn;
            // Alternate profile from the select pin
            wire altSel = synthCfg_q[s].fsFromPin ? fracFsPin[s] : synthCfg_q[s].fsRegSel;
            wire [4:0] magRaw = altSel ? synthCfg_q[s].magB : synthCfg_q[s].magA;
            // Magnitude held inside 0.1 to 2.5 percent
            wire [4:0] magLim = (magRaw < SPREAD_MAG_MIN) ? SPREAD_MAG_MIN :
                (magRaw > SPREAD_MAG_MAX) ? SPREAD_MAG_MAX : magRaw;
            wire centerSel = altSel ? synthCfg_q[s].centerB : synthCfg_q[s].centerA;

            always_ff @(posedge clk)
            begin
                if (!rstn)
                    spread_q <= '0;
                else
                begin
                    spread_q.spreadOn <= spreadOn;
                    spread_q.center <= centerSel;
                    spread_q.magnitude <= magLim;
                    spread_q.altProfile <= altSel;
                end
            end

            assign synthSpread[s] = spread_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Output pairs: divider, synchronous gating, polarity

    genvar o;
    generate
        for (o = 0; o < NUM_OUT; o++)
        begin : gOut
            logic [7:0] phase_q;
            logic [7:0] phase_d;
            logic running_q;
            logic truePin_q;
            logic compPin_q;
            logic driverOn_q;
            logic [2:0] skew_q;

            // Divide value A or B, pin wins when assigned
            wire divSel = outCfg_q[o].fsFromPin ? intFsPin[o] : outCfg_q[o].fsRegSel;
            wire [7:0] divRaw = divSel ? outCfg_q[o].divB : outCfg_q[o].divA;
            // Values below 8 are raised to 8
            wire [7:0] divVal = (divRaw < DIV_MIN) ? DIV_MIN : divRaw;
            wire periodEnd = (phase_q >= divVal - 8'h01);
            // Enable pin is active low; it may serve one, a bank or all
            // An index past the fitted pins reads as disabled, not unknown
            wire oeIdxOk = (int'(outCfg_q[o].oePinIdx) < NUM_OE_PIN);
            wire pinEnable = oeIdxOk && !oeLowPin[outCfg_q[o].oePinIdx];
            wire wantOn = outCfg_q[o].oeFromPin ? pinEnable : outCfg_q[o].oeRegEnable;
            // High for the first half of each period
            wire clkLevel = (phase_q < {1'b0, divVal[7:1]});
            wire trueLevel = clkLevel ^ outCfg_q[o].trueInvert;
            // Differential complements; single-ended follows polarity bit
            wire compLevel = outCfg_q[o].singleEnded ? (trueLevel ^ outCfg_q[o].compInvert) :
                !trueLevel;

            // Counter restarts at every period end so a resumed clock is whole
            assign phase_d = (periodEnd || !running_q) ? 8'h00 : phase_q + 8'h01;

            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    phase_q <= '0;
                    running_q <= 1'b0;
                end
                else
                begin
                    phase_q <= phase_d;
                    // State changes only at the period boundary, no runt
                    if (periodEnd || !running_q)
                        running_q <= wantOn;
                end
            end

            // Both pins of a pair gate together and rest low
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    truePin_q <= 1'b0;
                    compPin_q <= 1'b0;
                    driverOn_q <= 1'b0;
                    skew_q <= '0;
                end
                else
                begin
                    truePin_q <= running_q & trueLevel;
                    compPin_q <= running_q & compLevel;
                    driverOn_q <= running_q;
                    // Steps beyond the range are clamped
                    skew_q <= (outCfg_q[o].skewSteps > SKEW_MAX_STEPS) ? SKEW_MAX_STEPS :
                        outCfg_q[o].skewSteps;
                end
            end

            assign outPairs[o] = '{truePin: truePin_q, compPin: compPin_q,
                driverOn: driverOn_q, skewSteps: skew_q};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Status outputs

    assign targetAddr = targetAddr_q;
    assign sourceSelect = sourceSelect_q;
    assign bootDone = bootDone_q;

endmodule // ccp_clock_output_ctrl

// File: tb/ccp_clock_output_ctrl_sva.sv
// Checker: port-level timing of output gating, spread pins and address
`timescale 1ns/10ps
module ccp_clock_output_ctrl_sva #(
    parameter int NUM_OUT = ccp_pkg::NUM_OUT,
    parameter int NUM_SYNTH = ccp_pkg::NUM_SYNTH,
    parameter int NUM_OE_PIN = ccp_pkg::NUM_OE_PIN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins
    input wire logic [NUM_SYNTH-1:0] spreadEnablePins,
    input wire logic [NUM_OE_PIN-1:0] outputEnableLowPins,
    // Outputs
    input wire ccp_pkg::ccp_pair_type [NUM_OUT-1:0] outPairs,
    input wire ccp_pkg::ccp_spread_type [NUM_SYNTH-1:0] synthSpread,
    input wire logic [6:0] targetAddr,
    input wire logic [1:0] sourceSelect,
    input wire logic bootDone
);
import ccp_pkg::*;
default clocking cb @(posedge clk);
endclocking
default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////////////
// Pair 0 is differential and uninverted in every stored profile
AST_OFF_STATIC: assert property (!outPairs[0].driverOn |-> !outPairs[0].truePin &&
    !outPairs[0].compPin) else $error("disabled pair 0 not low");
AST_PAIR_TOGETHER: assert property (!outPairs[1].driverOn |-> !outPairs[1].truePin &&
    !outPairs[1].compPin) else $error("single-ended pair 1 half driven");
AST_DIFF_COMP: assert property (outPairs[0].driverOn |->
    outPairs[0].compPin != outPairs[0].truePin) else $error("pair 0 not complementary");
AST_RESUME_HIGH: assert property ($rose(outPairs[0].driverOn) |-> outPairs[0].truePin)
    else $error("pair 0 resumed mid period");
AST_STOP_AT_END: assert property ($fell(outPairs[0].driverOn) |-> !$past(outPairs[0].truePin))
    else $error("pair 0 cut inside high half");
AST_OE_OFF: assert property (outputEnableLowPins[0] [*8] |-> ##[0:270] !outPairs[0].driverOn)
    else $error("high enable pin left pair 0 on");
AST_OE_ON: assert property ((bootDone && !outputEnableLowPins[0]) [*8] |->
    ##[0:270] outPairs[0].driverOn) else $error("low enable pin left pair 0 off");
AST_SPREAD_ON: assert property ((bootDone && spreadEnablePins[0]) [*7] |->
    synthSpread[0].spreadOn) else $error("spread pin high but spread off");
AST_SPREAD_OFF: assert property ((bootDone && !spreadEnablePins[0]) [*7] |->
    !synthSpread[0].spreadOn) else $error("spread pin low but spread on");
AST_MAG_RANGE: assert property (synthSpread[0].spreadOn |->
    synthSpread[0].magnitude inside {[SPREAD_MAG_MIN:SPREAD_MAG_MAX]}) else $error("bad magnitude");
AST_ADDR_BASE: assert property (targetAddr[6:1] == TARGET_ADDR_BASE[6:1])
    else $error("target address upper bits wrong");
AST_SOURCE_LEGAL: assert property (sourceSelect != 2'h3)
    else $error("illegal source selected");
endmodule // ccp_clock_output_ctrl_sva
bind ccp_clock_output_ctrl ccp_clock_output_ctrl_sva #(.NUM_OUT(NUM_OUT), .NUM_SYNTH(NUM_SYNTH),
    .NUM_OE_PIN(NUM_OE_PIN)) u_ccp_clock_output_ctrl_sva (.clk(clk), .rstn(rstn),
    .spreadEnablePins(spreadEnablePins), .outputEnableLowPins(outputEnableLowPins),
    .outPairs(outPairs), .synthSpread(synthSpread), .targetAddr(targetAddr),
    .sourceSelect(sourceSelect), .bootDone(bootDone));

// File: tb/ccp_board_model.sv
// Partner model: board side holding the stored configuration profiles
`timescale 1ns/10ps
module ccp_board_model (
    // Stored profiles
    output ccp_pkg::ccp_out_cfg_type [1:0][ccp_pkg::NUM_OUT-1:0] nvmOutCfg,
    output ccp_pkg::ccp_synth_cfg_type [1:0][ccp_pkg::NUM_SYNTH-1:0] nvmSynthCfg,
    output ccp_pkg::ccp_misc_cfg_type [1:0] nvmMiscCfg
);
import ccp_pkg::*;
////////////////////////////////////////////////////////////////////////////////
function automatic ccp_out_cfg_type outCfg(logic [7:0] a, logic se, logic pinOe);
    ccp_out_cfg_type c;
    c = '0;
    c.divA = a;
    c.divB = 8'h0c;
    c.fsFromPin = pinOe;
    c.singleEnded = se;
    c.skewSteps = 3'h3;
    c.oeFromPin = pinOe;
    c.oeRegEnable = 1'b1;
    return c;
endfunction
always_comb
begin
    for (int p = 0; p < 2; p++)
    begin
        // Profiles differ only in source, so the loaded one is visible
        nvmMiscCfg[p] = '0;
        nvmMiscCfg[p].srcReg = p[0] ? SRC_CLOCK_THREE : SRC_CLOCK_TWO;
        nvmOutCfg[p][0] = outCfg(8'h08, 1'b0, 1'b1);
        nvmOutCfg[p][1] = outCfg(8'h0a, 1'b1, 1'b1);
        for (int o = 2; o < NUM_OUT; o++)
        begin
            nvmOutCfg[p][o] = outCfg(8'h09, 1'b0, 1'b0);
        end
        // Synth 0 pin driven, profile A is the 0.5 percent down spread
        nvmSynthCfg[p][0] = {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 5'h05, 1'b1, 5'h19};
        nvmSynthCfg[p][1] = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h01, 1'b0, 5'h01};
    end
end
endmodule // ccp_board_model

// File: tb/test_clock_output_pin_control.sv
// Testbench: pins, profiles and volatile configuration of the clock output control
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        numChecks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module test_clock_output_pin_control;
import ccp_pkg::*;
logic clk;
logic rstn;
logic [NUM_SYNTH-1:0] spreadEnablePins;
logic [NUM_OUT-1:0] integerFreqSelect;
logic [NUM_SYNTH-1:0] fractionalFreqSelect;
logic [NUM_OE_PIN-1:0] outputEnableLowPins;
logic addrSelectPin;
logic [1:0] inputSourceSelect;
logic [NUM_PROF_PIN-1:0] profileSelectPins;
ccp_out_cfg_type [1:0][NUM_OUT-1:0] nvmOutCfg;
ccp_synth_cfg_type [1:0][NUM_SYNTH-1:0] nvmSynthCfg;
ccp_misc_cfg_type [1:0] nvmMiscCfg;
logic hostOutWr;
logic [2:0] hostOutIdx;
ccp_out_cfg_type hostOutData;
logic hostSynthWr;
logic [0:0] hostSynthIdx;
ccp_synth_cfg_type hostSynthData;
logic hostMiscWr;
ccp_misc_cfg_type hostMiscData;
ccp_pair_type [NUM_OUT-1:0] outPairs;
ccp_spread_type [NUM_SYNTH-1:0] synthSpread;
logic [6:0] targetAddr;
logic [1:0] sourceSelect;
logic bootDone;
int miscompares;
int numChecks;
////////////////////////////////////////////////////////////////////////////////
ccp_board_model u_ccp_board_model (.nvmOutCfg(nvmOutCfg), .nvmSynthCfg(nvmSynthCfg),
    .nvmMiscCfg(nvmMiscCfg));
ccp_clock_output_ctrl u_ccp_clock_output_ctrl (.clk(clk), .rstn(rstn),
    .spreadEnablePins(spreadEnablePins), .integerFreqSelect(integerFreqSelect),
    .fractionalFreqSelect(fractionalFreqSelect), .outputEnableLowPins(outputEnableLowPins),
    .addrSelectPin(addrSelectPin), .inputSourceSelect(inputSourceSelect),
    .profileSelectPins(profileSelectPins), .nvmOutCfg(nvmOutCfg), .nvmSynthCfg(nvmSynthCfg),
    .nvmMiscCfg(nvmMiscCfg), .hostOutWr(hostOutWr), .hostOutIdx(hostOutIdx),
    .hostOutData(hostOutData), .hostSynthWr(hostSynthWr), .hostSynthIdx(hostSynthIdx),
    .hostSynthData(hostSynthData), .hostMiscWr(hostMiscWr), .hostMiscData(hostMiscData),
    .outPairs(outPairs), .synthSpread(synthSpread), .targetAddr(targetAddr),
    .sourceSelect(sourceSelect), .bootDone(bootDone));
initial
begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task automatic final_report;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
task automatic cyc(input int n);
    repeat (n) @(negedge clk);
endtask
task automatic timed_out(input int k);
    if (k >= 400)
    begin
        miscompares++;
        final_report();
    end
endtask
task automatic wait_boot;
    int k;
    k = 0;
    while (bootDone !== 1'b1 && k < 400)
    begin
        cyc(1);
        k++;
    end
    timed_out(k);
    cyc(4);
endtask
// Selection fixed while reset holds, so the profile sample is clean
task automatic do_reset(input logic prof);
    @(posedge clk);
    rstn <= 1'b0;
    profileSelectPins <= prof;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    wait_boot();
endtask
task automatic run_while(input int o, input logic lvl, inout int k, inout int n);
    while (outPairs[o].truePin === lvl && k < 400)
    begin
        cyc(1);
        k++;
        n++;
    end
endtask
task automatic high_len(input int o, output int n);
    int k;
    k = 0;
    n = 0;
    run_while(o, 1'b1, k, n);
    run_while(o, 1'b0, k, n);
    n = 0;
    run_while(o, 1'b1, k, n);
    timed_out(k);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_profile;
    do_reset(1'b1);
    `CHK(sourceSelect, SRC_CLOCK_THREE)
    do_reset(1'b0);
    `CHK(sourceSelect, SRC_CLOCK_TWO)
    `CHK(outPairs[2].driverOn, 1'b1)
    `CHK(bootDone, 1'b1)
endtask
task automatic t_divider;
    int n;
    high_len(0, n);
    `CHK(n, 4)
    high_len(1, n);
    `CHK(n, 5)
    `CHK(outPairs[1].compPin, outPairs[1].truePin)
    @(posedge clk);
    integerFreqSelect[0] <= 1'b1;
    cyc(40);
    high_len(0, n);
    `CHK(n, 6)
    @(posedge clk);
    integerFreqSelect[0] <= 1'b0;
endtask
task automatic t_oe;
    int k;
    @(posedge clk);
    outputEnableLowPins <= 4'he;
    cyc(40);
    `CHK(outPairs[0].driverOn, 1'b1)
    @(posedge clk);
    outputEnableLowPins[0] <= 1'b1;
    k = 0;
    while (outPairs[0].driverOn === 1'b1 && k < 400)
    begin
        cyc(1);
        k++;
    end
    timed_out(k);
    `CHK(k <= OE_DISABLE_MAX_PERIODS * 8, 1'b1)
    cyc(20);
    `CHK({outPairs[1].driverOn, outPairs[1].truePin, outPairs[1].compPin}, 3'h0)
    `CHK(outPairs[2].driverOn, 1'b1)
    @(posedge clk);
    outputEnableLowPins <= 4'h0;
    k = 0;
    while (outPairs[0].driverOn !== 1'b1 && k < 400)
    begin
        cyc(1);
        k++;
    end
    timed_out(k);
    `CHK(outPairs[0].truePin, 1'b1)
endtask
task automatic t_spread;
    @(posedge clk);
    spreadEnablePins <= 2'h1;
    cyc(8);
    `CHK(synthSpread[0], {1'b1, 1'b0, 5'h05, 1'b0})
    `CHK(synthSpread[1].spreadOn, 1'b1)
    @(posedge clk);
    fractionalFreqSelect <= 2'h3;
    cyc(8);
    `CHK(synthSpread[0], {1'b1, 1'b1, SPREAD_MAG_MAX, 1'b1})
    `CHK(synthSpread[1].altProfile, 1'b0)
    @(posedge clk);
    spreadEnablePins <= 2'h2;
    fractionalFreqSelect <= 2'h0;
    cyc(8);
    `CHK(synthSpread[0].spreadOn, 1'b0)
endtask
task automatic t_host;
    ccp_out_cfg_type c;
    c = '0;
    c.divA = 8'h09;
    c.singleEnded = 1'b1;
    c.compInvert = 1'b1;
    c.skewSteps = 3'h7;
    c.oeRegEnable = 1'b1;
    @(posedge clk);
    addrSelectPin <= 1'b1;
    inputSourceSelect <= SRC_CLOCK_THREE;
    cyc(8);
    `CHK(targetAddr, 7'h6a)
    @(posedge clk);
    hostOutWr <= 1'b1;
    hostOutIdx <= 3'h2;
    hostOutData <= c;
    hostSynthWr <= 1'b1;
    hostSynthIdx <= 1'b1;
    hostMiscWr <= 1'b1;
    hostMiscData <= {1'b1, 2'h0, 1'b1};
    @(posedge clk);
    hostOutWr <= 1'b0;
    hostSynthWr <= 1'b0;
    hostMiscWr <= 1'b0;
    cyc(12);
    `CHK(outPairs[2].skewSteps, 3'h7)
    `CHK(outPairs[2].compPin, ~outPairs[2].truePin)
    `CHK(synthSpread[1].spreadOn, 1'b0)
    `CHK(targetAddr, 7'h6b)
    `CHK(sourceSelect, SRC_CLOCK_THREE)
    @(posedge clk);
    inputSourceSelect <= 2'h3;
    cyc(8);
    `CHK(sourceSelect, SRC_CRYSTAL)
    do_reset(1'b0);
    `CHK({outPairs[2].skewSteps, targetAddr}, {3'h3, 7'h6a})
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    miscompares = 0;
    numChecks = 0;
    rstn = 1'b0;
    spreadEnablePins = '0;
    integerFreqSelect = '0;
    fractionalFreqSelect = '0;
    outputEnableLowPins = '0;
    addrSelectPin = 1'b0;
    inputSourceSelect = SRC_CRYSTAL;
    profileSelectPins = '0;
    hostOutWr = 1'b0;
    hostOutIdx = '0;
    hostOutData = '0;
    hostSynthWr = 1'b0;
    hostSynthIdx = '0;
    hostSynthData = '0;
    hostMiscWr = 1'b0;
    hostMiscData = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wait_boot();
    t_profile();
    t_divider();
    t_oe();
    t_spread();
    t_host();
    final_report();
end
endmodule // test_clock_output_pin_control
